//--- hdl/gpsr_top.sv
`timescale 1ns/1ps
// Functional notes
// - enabled peripheral takes the pin over
// - reset: inputs, no pullups, direction zero
// - pullup only for general-purpose inputs
// - direction drives buffer and read source
// - input buffer on unless analog/output-only
// - digital peripheral owns buffer, direction picks read
// - analog: buffers off, input reads zero
// - analog beats shared digital function
// - full power-down restores reset defaults
// - partial power-down latches pin state
// - standby keeps all pin states
// - bit 4 flags full power-down recovery
// - bit 3 flags partial power-down recovery
// - writing ack bit 2 clears flag
// - bit 1 enables power-down modes
// - bit 0 picks full or partial
// - control bits accept first write only
// - read pin or latch, writes latched only in run and standby
// - pullup off for outputs and analog
module gpsr_top #(
	parameter int width = gpsr_pkg::gpsr_pins
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [width-1:0] pin_in,
	output logic [width-1:0] pin_out,
	output logic [width-1:0] pin_oe,
	output logic [width-1:0] pin_pull,
	output logic [width-1:0] pin_ibe,
	input wire logic [width-1:0] periph_dig_oe,
	input wire logic [width-1:0] periph_dig_out,
	output logic [width-1:0] periph_in,
	output logic reset_pin_func,
	output logic background_mode_select_pin,
	output logic [1:0] power_state
);
	import gpsr_pkg::*;
	// ==========================================================
	// storage
	// all port registers are plain flip-flops cleared by reset and by a power-down wake
	// the hold set freezes the pin drive while partial power-down is in force
	// next_state is the combinational next value of state; power_state is a plain copy of state, not of next_state
	logic [width-1:0] port_data_latch; // written data
	logic [width-1:0] pin_direction_bit; // direction
	logic [width-1:0] pin_pullup_enable_bit; // pullup enables
	logic [width-1:0] dig_en; // shared digital enables
	logic [width-1:0] ana_en; // analog enables
	logic reset_func_en; // reset_shared_pin still reset
	logic bgsel_func_en; // output_only_pin still background
	logic full_powerdown_recovered_flag; // set after full power-down
	logic partial_powerdown_recovered_flag; // set after partial power-down
	logic powerdown_enable_once; // power-down enable
	logic powerdown_mode_select_once; // 1 partial, 0 full
	logic ctrl_written; // first write consumed
	gpsr_state_e state; // power state
	gpsr_state_e next_state; // next power state
	logic [width-1:0] hold_out; // pin latches for partial mode
	logic [width-1:0] hold_oe;
	logic [width-1:0] hold_pull;
	logic [width-1:0] hold_ibe;
	logic [width-1:0] pin_sync; // synchronised pin levels
	logic [width-1:0] mux_out; // live mux values
	logic [width-1:0] mux_oe;
	logic [width-1:0] mux_pull;
	logic [width-1:0] mux_ibe;
	logic [width-1:0] read_val; // port data read value
	logic [width-1:0] in_ok; // pins with an input buffer
	logic [width-1:0] eff_dig; // digital enables incl. special pins
	logic [width-1:0] eff_dig_oe;
	logic [width-1:0] eff_dig_out;
	logic [7:0] next_rdata; // read mux
	// ==========================================================
	// decode
	// one strobe per register; unmapped offsets decode to nothing and are dropped
	// the stop and wake offsets carry no storage, any write there is the command
	// only the acknowledge bit of a status write acts outside the first control write
	wire wr_data = reg_write & (reg_addr == gpsr_off_data);
	wire wr_dir = reg_write & (reg_addr == gpsr_off_dir);
	wire wr_pull = reg_write & (reg_addr == gpsr_off_pull);
	wire wr_dig = reg_write & (reg_addr == gpsr_off_dig);
	wire wr_ana = reg_write & (reg_addr == gpsr_off_ana);
	wire wr_pmsc = reg_write & (reg_addr == gpsr_off_pmsc);
	wire wr_stop = reg_write & (reg_addr == gpsr_off_stop);
	wire wr_wake = reg_write & (reg_addr == gpsr_off_wake);
	wire ack_ppd = wr_pmsc & reg_wdata[gpsr_bit_ack];
	wire ctrl_take = wr_pmsc & ~ctrl_written;
	wire in_run = (state == gpsr_run);
	wire full_wake = (state == gpsr_full) & wr_wake;
	wire part_wake = (state == gpsr_partial) & wr_wake;
	wire regs_live = in_run | (state == gpsr_standby);
	// ==========================================================
	// special pins: reset_shared_pin and output_only_pin act as a digital function
	// the reset function pin is never driven by the port while that function holds it
	// the output-only pin has no input buffer, so it never feeds reads or peripherals
	// writing the shared digital enable with the pin's bit clear hands it to the port
	always_comb
	begin
		in_ok = {width{1'b1}};
		in_ok[gpsr_out_only_idx] = 1'b0;
		eff_dig = dig_en;
		eff_dig[gpsr_reset_pin_idx] = dig_en[gpsr_reset_pin_idx] | reset_func_en;
		eff_dig[gpsr_out_only_idx] = dig_en[gpsr_out_only_idx] | bgsel_func_en;
		eff_dig_oe = periph_dig_oe;
		eff_dig_oe[gpsr_reset_pin_idx] = reset_func_en ? 1'b0 : periph_dig_oe[gpsr_reset_pin_idx];
		eff_dig_out = periph_dig_out;
	end
	// ==========================================================
	// input synchroniser
	// pin levels come from the board and are asynchronous to sys_clk
	// reads and peripheral inputs therefore see each level two edges late
	gpsr_sync #(
		.width(width)
	) u_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);
	// ==========================================================
	// pin multiplexing
	// priority per pin: analog first, then shared digital, then the port registers
	// the mux outputs are live values; the pin drive below picks them or the hold set
	gpsr_pinmux #(
		.width(width)
	) u_mux (
		.dir(pin_direction_bit),
		.pull(pin_pullup_enable_bit),
		.data(port_data_latch),
		.dig_en(eff_dig),
		.dig_oe(eff_dig_oe),
		.dig_out(eff_dig_out),
		.ana_en(ana_en),
		.in_ok(in_ok),
		.pin_level(pin_sync),
		.pin_out(mux_out),
		.pin_oe(mux_oe),
		.pin_pull(mux_pull),
		.pin_ibe(mux_ibe),
		.read_val(read_val)
	);
	// ==========================================================
	// pin drive: live in run/standby, latched in partial, off in full
	assign pin_out = (state == gpsr_partial) ? hold_out : ((state == gpsr_full) ? '0 : mux_out);
	assign pin_oe = (state == gpsr_partial) ? hold_oe : ((state == gpsr_full) ? '0 : mux_oe);
	assign pin_pull = (state == gpsr_partial) ? hold_pull : ((state == gpsr_full) ? '0 : mux_pull);
	assign pin_ibe = (state == gpsr_partial) ? hold_ibe : ((state == gpsr_full) ? '0 : mux_ibe);
	// peripherals see a pin only through the buffer that is enabled at the pin;
	// the live mux value would leak levels while the buffers are off in power-down
	assign periph_in = pin_sync & pin_ibe;
	// the special functions are reported so the board side knows who owns those pins
	assign reset_pin_func = reset_func_en;
	assign background_mode_select_pin = bgsel_func_en;
	assign power_state = state;
	// ==========================================================
	// stop sequencing
	// a stop command only acts from run; the control bits pick which stop mode
	// with power-down disabled the block always parks in standby with logic powered
	// any wake command returns to run; what a wake clears sits with the registers
	always_comb
	begin
		next_state = state;
		case (state)
			gpsr_run:
			begin
				if (wr_stop)
				begin
					if (!powerdown_enable_once)
						next_state = gpsr_standby;
					else if (powerdown_mode_select_once)
						next_state = gpsr_partial;
					else
						next_state = gpsr_full;
				end
			end
			gpsr_standby, gpsr_partial, gpsr_full:
			begin
				if (wr_wake)
					next_state = gpsr_run;
			end
			default:
				next_state = gpsr_run;
		endcase
	end
	// state register
	// synchronous reset always brings the block back to run
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			state <= gpsr_run;
		else
			state <= next_state;
	end
	// ==========================================================
	// pin hold latches, captured as the partial mode is entered
	// capture happens on every stop command, which is harmless for the other modes
	// because only the partial state ever selects the hold set for the pins
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			hold_out <= '0;
			hold_oe <= '0;
			hold_pull <= '0;
			hold_ibe <= '0;
		end
		else if (in_run & wr_stop)
		begin
			hold_out <= mux_out;
			hold_oe <= mux_oe;
			hold_pull <= mux_pull;
			hold_ibe <= mux_ibe;
		end
	end
	// ==========================================================
	// port registers; lost on full and partial power-down wake
	// a full or partial wake behaves like a reset for these registers, since they
	// lost power; writes are refused while the pins are frozen or powered down
	// a standby stop keeps them, as the logic stays powered there
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || full_wake || part_wake)
		begin
			port_data_latch <= gpsr_rst_port[width-1:0];
			pin_direction_bit <= gpsr_rst_port[width-1:0];
			pin_pullup_enable_bit <= gpsr_rst_port[width-1:0];
			dig_en <= gpsr_rst_port[width-1:0];
			ana_en <= gpsr_rst_port[width-1:0];
		end
		else if (regs_live)
		begin
			if (wr_data)
				port_data_latch <= reg_wdata[width-1:0];
			if (wr_dir)
				pin_direction_bit <= reg_wdata[width-1:0];
			if (wr_pull)
				pin_pullup_enable_bit <= reg_wdata[width-1:0];
			if (wr_dig)
				dig_en <= reg_wdata[width-1:0];
			if (wr_ana)
				ana_en <= reg_wdata[width-1:0];
		end
	end
	// ==========================================================
	// special pin functions: released by writing the digital enable register
	// only a full wake brings the special functions back; partial power-down keeps
	// them as software left them before the stop
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || full_wake)
		begin
			reset_func_en <= 1'b1;
			bgsel_func_en <= 1'b1;
		end
		else if (wr_dig & regs_live)
		begin
			reset_func_en <= reg_wdata[gpsr_reset_pin_idx];
			bgsel_func_en <= reg_wdata[gpsr_out_only_idx];
		end
	end
	// ==========================================================
	// power control bits and recovery flags
	// the recovery flags are set by hardware on wake and read through the status register
	// a partial wake and an acknowledge in one cycle leave the flag set, so software
	// never loses a recovery that it has not seen yet
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			full_powerdown_recovered_flag <= gpsr_rst_bit;
			partial_powerdown_recovered_flag <= gpsr_rst_bit;
			powerdown_enable_once <= gpsr_rst_bit;
			powerdown_mode_select_once <= gpsr_rst_bit;
			ctrl_written <= gpsr_rst_bit;
		end
		else if (full_wake)
		begin
			full_powerdown_recovered_flag <= 1'b1;
			partial_powerdown_recovered_flag <= 1'b0;
			powerdown_enable_once <= gpsr_rst_bit;
			powerdown_mode_select_once <= gpsr_rst_bit;
			ctrl_written <= gpsr_rst_bit;
		end
		else
		begin
			if (part_wake)
				partial_powerdown_recovered_flag <= 1'b1;
			else if (ack_ppd)
				partial_powerdown_recovered_flag <= 1'b0;
			if (ctrl_take)
			begin
				powerdown_enable_once <= reg_wdata[gpsr_bit_pd_enable];
				powerdown_mode_select_once <= reg_wdata[gpsr_bit_pd_mode];
				ctrl_written <= 1'b1;
			end
		end
	end
	// ==========================================================
	// read mux, data one cycle after the strobe
	// unmapped offsets and write-only bits read as zero
	// the stop offset reports the power state to software
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			gpsr_off_data: next_rdata[width-1:0] = read_val;
			gpsr_off_dir: next_rdata[width-1:0] = pin_direction_bit;
			gpsr_off_pull: next_rdata[width-1:0] = pin_pullup_enable_bit;
			gpsr_off_dig: next_rdata[width-1:0] = dig_en;
			gpsr_off_ana: next_rdata[width-1:0] = ana_en;
			gpsr_off_pmsc:
			begin
				next_rdata[gpsr_bit_full_flag] = full_powerdown_recovered_flag;
				next_rdata[gpsr_bit_part_flag] = partial_powerdown_recovered_flag;
				next_rdata[gpsr_bit_pd_enable] = powerdown_enable_once;
				next_rdata[gpsr_bit_pd_mode] = powerdown_mode_select_once;
			end
			gpsr_off_stop: next_rdata[1:0] = state;
			default: next_rdata = 8'h00;
		endcase
	end
	// read data register; zero outside the answer cycle
	// reg_rdata is only valid in the cycle after the read strobe
	// a cleared bus between answers keeps stale data from passing for a reply
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 8'h00;
	end
endmodule // gpsr_top

//--- hdl/gpsr_pkg.sv
package gpsr_pkg;
	// ==========================================================
	// register offsets
	localparam logic [3:0] gpsr_off_data = 4'h0; // port data latch
	localparam logic [3:0] gpsr_off_dir = 4'h1; // direction bits
	localparam logic [3:0] gpsr_off_pull = 4'h2; // pullup enable bits
	localparam logic [3:0] gpsr_off_dig = 4'h3; // shared digital enable
	localparam logic [3:0] gpsr_off_ana = 4'h4; // analog enable
	localparam logic [3:0] gpsr_off_pmsc = 4'h5; // power_down_status_control
	localparam logic [3:0] gpsr_off_stop = 4'h6; // stop command
	localparam logic [3:0] gpsr_off_wake = 4'h7; // wake command
	// ==========================================================
	// power_down_status_control fields
	localparam int gpsr_bit_full_flag = 4; // full_powerdown_recovered_flag
	localparam int gpsr_bit_part_flag = 3; // partial_powerdown_recovered_flag
	localparam int gpsr_bit_ack = 2; // partial_powerdown_ack
	localparam int gpsr_bit_pd_enable = 1; // powerdown_enable_once
	localparam int gpsr_bit_pd_mode = 0; // powerdown_mode_select_once
	// ==========================================================
	// reset values
	localparam logic [7:0] gpsr_rst_port = 8'h00; // all port registers
	localparam logic gpsr_rst_bit = 1'b0; // single control bits
	localparam int gpsr_pins = 8; // pins per port
	localparam int gpsr_out_only_idx = 6; // output_only_pin index
	localparam int gpsr_reset_pin_idx = 2; // reset_shared_pin index
	// ==========================================================
	// power states
	typedef enum logic [1:0]
	{
		gpsr_run = 2'b00,
		gpsr_standby = 2'b01, // powered_standby_mode
		gpsr_partial = 2'b11, // partial_power_down_mode
		gpsr_full = 2'b10 // full_power_down_mode
	} gpsr_state_e;
endpackage

//--- hdl/gpsr_sync.sv
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for pin inputs
module gpsr_sync #(
	parameter int width = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] meta; // first stage, read only by second
	// two stages
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			meta <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // gpsr_sync

//--- hdl/gpsr_pinmux.sv
`timescale 1ns/1ps
// ==========================================================
// per-pin buffer and pullup selection
module gpsr_pinmux #(
	parameter int width = 8
) (
	input wire logic [width-1:0] dir,
	input wire logic [width-1:0] pull,
	input wire logic [width-1:0] data,
	input wire logic [width-1:0] dig_en,
	input wire logic [width-1:0] dig_oe,
	input wire logic [width-1:0] dig_out,
	input wire logic [width-1:0] ana_en,
	input wire logic [width-1:0] in_ok,
	input wire logic [width-1:0] pin_level,
	output logic [width-1:0] pin_out,
	output logic [width-1:0] pin_oe,
	output logic [width-1:0] pin_pull,
	output logic [width-1:0] pin_ibe,
	output logic [width-1:0] read_val
);
	genvar i;
	// one slice per pin
	generate
		for (i = 0; i < width; i++)
		begin : g_pin
			wire dig_own = dig_en[i] & ~ana_en[i]; // analog beats digital
			wire ibe = in_ok[i] & ~ana_en[i]; // input buffer enable
			assign pin_oe[i] = ana_en[i] ? 1'b0 : (dig_own ? dig_oe[i] : dir[i]);
			assign pin_out[i] = dig_own ? dig_out[i] : data[i];
			assign pin_pull[i] = pull[i] & ~pin_oe[i] & ~ana_en[i] & ~dig_own;
			assign pin_ibe[i] = ibe;
			assign read_val[i] = dir[i] ? data[i] : (ibe & pin_level[i]);
		end
	endgenerate
endmodule // gpsr_pinmux

//--- verif/gpsr_board.sv
`timescale 1ns/1ps
// ==========================================================
// board circuitry on the port pins
module gpsr_board (
	input wire logic sys_clk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pull,
	input wire logic [7:0] board_en,
	input wire logic [7:0] board_val,
	output logic [7:0] pin_in
);
	logic [7:0] last; // level seen at the previous edge
	// remember levels so a floating pin can wander
	always_ff @(posedge sys_clk)
	begin
		last <= pin_in;
	end
	// device drive first, then board drive, then pullup or a wandering level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_en & board_val) | (~pin_oe & ~board_en & (pin_pull | ~last));
endmodule // gpsr_board

//--- verif/gpsr_checker.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checker for the pin control block
module gpsr_checker #(
	parameter int width = 8
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	input wire logic [width-1:0] pin_in,
	input wire logic [width-1:0] pin_out,
	input wire logic [width-1:0] pin_oe,
	input wire logic [width-1:0] pin_pull,
	input wire logic [width-1:0] pin_ibe,
	input wire logic [width-1:0] periph_dig_oe,
	input wire logic [width-1:0] periph_dig_out,
	input wire logic [width-1:0] periph_in,
	input wire logic reset_pin_func,
	input wire logic background_mode_select_pin,
	input wire logic [1:0] power_state
);
	import gpsr_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// stop and wake steps
	sequence s_stop_cmd;
		reg_write && reg_addr == gpsr_off_stop && power_state == gpsr_run;
	endsequence
	sequence s_wake_cmd;
		reg_write && reg_addr == gpsr_off_wake && power_state != gpsr_run;
	endsequence
	sequence s_partial_two;
		power_state == gpsr_partial ##1 power_state == gpsr_partial;
	endsequence
	// ==========================================================
	// assertions
	a_reset_defaults:
		assert property ($rose(reset_n) |-> pin_oe == '0 && pin_pull == '0 && reset_pin_func
			&& background_mode_select_pin && power_state == gpsr_run) else $error("pins not at defaults after reset");
	a_pull_not_out:
		assert property ((pin_pull & pin_oe) == '0) else $error("pullup on a driven pin");
	a_out_only_ibe:
		assert property (!pin_ibe[gpsr_out_only_idx]) else $error("output-only pin has input buffer");
	a_periph_in_gated:
		assert property ((periph_in & ~pin_ibe) == '0) else $error("input seen through disabled buffer");
	a_stop_entry:
		assert property (s_stop_cmd |=> power_state != gpsr_run) else $error("stop command not taken");
	a_no_stray_stop:
		assert property (power_state == gpsr_run && !(reg_write && reg_addr == gpsr_off_stop) |=> power_state == gpsr_run)
		else $error("stop state without command");
	a_wake_exit:
		assert property (s_wake_cmd |=> power_state == gpsr_run) else $error("wake command not taken");
	a_partial_hold:
		assert property (s_partial_two |-> $stable(pin_out) && $stable(pin_oe) && $stable(pin_pull))
		else $error("pins moved in partial power-down");
	a_standby_entry:
		assert property (power_state == gpsr_standby && $past(power_state) == gpsr_run |-> $stable(pin_oe) && $stable(pin_out))
		else $error("pins moved on standby entry");
	a_full_defaults:
		assert property (power_state == gpsr_full |-> pin_oe == '0 && pin_pull == '0) else $error("pins driven in full power-down");
	a_ack_reads_zero:
		assert property (reg_read && reg_addr == gpsr_off_pmsc |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[gpsr_bit_ack])
		else $error("status register unused bits not zero");
endmodule // gpsr_checker
bind gpsr_top gpsr_checker #(.width(width)) u_gpsr_checker (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
	.pin_pull(pin_pull), .pin_ibe(pin_ibe), .periph_dig_oe(periph_dig_oe), .periph_dig_out(periph_dig_out),
	.periph_in(periph_in), .reset_pin_func(reset_pin_func), .background_mode_select_pin(background_mode_select_pin),
	.power_state(power_state)
);

//--- verif/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the pin control block
module testbench;
	import gpsr_pkg::*;
	logic sys_clk = 1'b0; // 25 MHz
	logic reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pull, pin_ibe, periph_in;
	logic [7:0] periph_dig_oe = 8'h00;
	logic [7:0] periph_dig_out = 8'h00;
	logic [7:0] board_en = 8'hff; // board drives every pin at first
	logic [7:0] board_val = 8'h00;
	logic reset_pin_func, background_mode_select_pin;
	logic [1:0] power_state;
	logic [7:0] data, dir, pull, dig, ana, poe, pout, ben, bval, oe_x, out_x, lvl, ibe_x, pull_gp, m, got;
	logic [7:0] cfg_t [3] = '{8'h00, 8'h03, 8'h02}; // standby, partial, full
	logic [7:0] st_t [3] = '{8'h01, 8'h03, 8'h02}; // state read while stopped
	logic [7:0] pm_t [3] = '{8'h00, 8'h0b, 8'h10}; // status after wake
	int err_count = 0;
	int comparisons = 0;
	gpsr_top #(.width(8)) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pull(pin_pull), .pin_ibe(pin_ibe), .periph_dig_oe(periph_dig_oe), .periph_dig_out(periph_dig_out),
		.periph_in(periph_in), .reset_pin_func(reset_pin_func),
		.background_mode_select_pin(background_mode_select_pin), .power_state(power_state)
	);
	gpsr_board u_board (
		.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull(pin_pull), .board_en(board_en),
		.board_val(board_val), .pin_in(pin_in)
	);
	initial forever #20 sys_clk = ~sys_clk;
	// ==========================================================
	// bus tasks and comparison
	task wr(input logic [3:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge sys_clk);
		reg_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	// data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask
	task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task do_reset;
		reset_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
	endtask
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// watchdog: the whole run needs well under 2000 cycles
	initial
	begin
		repeat (6000) @(posedge sys_clk);
		err_count++;
		$display("watchdog expired");
		summarize();
	end
	// ==========================================================
	// main sequence
	initial
	begin
		void'($urandom(15));
		do_reset();
		@(negedge sys_clk);
		chk("reset oe", 8'h00, pin_oe);
		chk("reset pull", 8'h00, pin_pull);
		chk("reset ibe", 8'hbf, pin_ibe);
		chk("special funcs", 8'h03, {6'h00, reset_pin_func, background_mode_select_pin});
		@(posedge sys_clk);
		for (int a = 0; a < 6; a++)
		begin
			rd(4'(a), got);
			chk("reset register", 8'h00, got);
		end
		wr(4'hc, 8'hff);
		rd(4'hc, got);
		chk("unmapped", 8'h00, got);
		wr(gpsr_off_dig, 8'h00);
		chk("released funcs", 8'h00, {6'h00, reset_pin_func, background_mode_select_pin});
		$display("reset test done");
		// random mixes of port, digital and analog control
		for (int i = 0; i < 24; i++)
		begin
			{data, dir, pull, dig} = $urandom;
			{ana, poe, pout, ben} = $urandom;
			bval = 8'($urandom);
			pull_gp = pull & ~dir & ~dig & ~ana & 8'hbf;
			ben = ben | ~pull_gp; // undriven inputs only where pulled up
			oe_x = ~ana & ((dig & poe & ~(8'h01 << gpsr_reset_pin_idx)) | (~dig & dir)); // reset function pin never driven
			out_x = (dig & pout) | (~dig & data);
			lvl = (oe_x & out_x) | (~oe_x & (~ben | bval));
			ibe_x = ~ana & 8'hbf;
			periph_dig_oe <= poe;
			periph_dig_out <= pout;
			board_en <= ben;
			board_val <= bval;
			wr(gpsr_off_data, data);
			wr(gpsr_off_pull, pull);
			wr(gpsr_off_dig, dig);
			wr(gpsr_off_ana, ana);
			wr(gpsr_off_dir, dir);
			repeat (2) @(posedge sys_clk);
			rd(gpsr_off_data, got);
			chk("port data", (dir & data) | (~dir & lvl & ibe_x), got);
			rd(gpsr_off_dir, got);
			chk("direction", dir, got);
			@(negedge sys_clk);
			chk("output enable", oe_x, pin_oe);
			chk("output value", out_x & oe_x, pin_out & oe_x);
			m = ~(dig & ~ana & ~poe) & 8'hbf;
			chk("pullup", pull_gp, pin_pull & m);
			chk("input buffer", ibe_x, pin_ibe);
			chk("peripheral input", lvl & ibe_x, periph_in);
			@(posedge sys_clk);
		end
		$display("pin mux test done");
		periph_dig_oe <= 8'h00;
		board_en <= 8'hff;
		// standby, partial and full power-down
		for (int k = 0; k < 3; k++)
		begin
			do_reset();
			wr(gpsr_off_dig, 8'h00);
			wr(gpsr_off_pmsc, cfg_t[k]);
			wr(gpsr_off_pmsc, cfg_t[k] ^ 8'h03);
			rd(gpsr_off_pmsc, got);
			chk("control bits", cfg_t[k], got);
			wr(gpsr_off_data, 8'h3c);
			wr(gpsr_off_dir, 8'ha5);
			wr(gpsr_off_stop, 8'h01);
			rd(gpsr_off_stop, got);
			chk("stop state", st_t[k], got);
			periph_dig_out <= 8'($urandom);
			board_val <= 8'($urandom);
			repeat (3) @(posedge sys_clk);
			@(negedge sys_clk);
			chk("stopped oe", k == 2 ? 8'h00 : 8'ha5, pin_oe);
			chk("stopped out", k == 2 ? 8'h00 : 8'h24, pin_out & pin_oe);
			@(posedge sys_clk);
			wr(gpsr_off_wake, 8'h01);
			rd(gpsr_off_pmsc, got);
			chk("wake flags", pm_t[k], got);
			rd(gpsr_off_dir, got);
			chk("wake direction", k == 0 ? 8'ha5 : 8'h00, got);
			if (k == 1)
			begin
				wr(gpsr_off_pmsc, 8'h04);
				rd(gpsr_off_pmsc, got);
				chk("acknowledge", 8'h03, got);
			end
			$display("power mode %0d done", k);
		end
		summarize();
	end
endmodule // testbench
